// *** src/sms_pkg.sv ***
// Package: constants, register map and carrier types for the supply sequencer
package sms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timer base
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned TICK_US         = 10;
  localparam int unsigned TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TW              = 17;   // Timer width in bits

  // Least times round up to whole ticks
  function automatic logic [TW-1:0] sms_ticks(input int unsigned us);
    return TW'((us + TICK_US - 1) / TICK_US);
  endfunction

  localparam int unsigned   DEGLITCH_US     = 45;
  localparam int unsigned   WARN_LEAD_US    = 60;
  localparam logic [TW-1:0] DEGLITCH_TICKS  = sms_ticks(DEGLITCH_US);
  localparam logic [TW-1:0] WARN_LEAD_TICKS = sms_ticks(WARN_LEAD_US);

  // Timing tables indexed by 3-bit code, in microseconds
  localparam int unsigned HI_HOLD_US [8] = '{200000, 150000, 100000, 80000,
                                             60000, 40000, 20000, 70};
  localparam int unsigned HI_DELAY_US [8] = '{1200000, 1000000, 800000, 400000,
                                              200000, 100000, 50000, 70};
  localparam int unsigned IG_HOLD_US [8] = '{10000, 20000, 30000, 40000,
                                             50000, 100000, 200000, 70};
  localparam int unsigned IG_DELAY_US [8] = '{100000, 50000, 200000, 400000,
                                              800000, 1000000, 1200000, 70};
  localparam int unsigned RS_HOLD_US [8] = '{200000, 150000, 100000, 50000,
                                             30000, 15000, 1000, 100};

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] REG_HI_OV     = 8'h01;
  localparam logic [7:0] REG_HI_UV     = 8'h02;
  localparam logic [7:0] REG_IG_ON     = 8'h03;
  localparam logic [7:0] REG_IG_OFF    = 8'h04;
  localparam logic [7:0] REG_LO_UV     = 8'h05;
  localparam logic [7:0] REG_HI_TIME   = 8'h10;
  localparam logic [7:0] REG_IG_TIME   = 8'h11;
  localparam logic [7:0] REG_RS_TIME   = 8'h12;
  localparam logic [7:0] REG_FAULT     = 8'h13;

  // Field positions
  localparam int unsigned HOLD_LSB  = 0;
  localparam int unsigned DELAY_LSB = 4;
  localparam int unsigned FLT_OV    = 0;
  localparam int unsigned FLT_UV    = 1;
  localparam int unsigned FLT_IGOFF = 2;
  localparam int unsigned FLT_LOUV  = 3;

  // Reset values
  localparam logic [3:0] HI_OV_RST   = 4'h0;   // 18.00 V
  localparam logic [3:0] HI_UV_RST   = 4'h0;   // 8.43 V
  localparam logic [3:0] IG_ON_RST   = 4'h0;
  localparam logic [3:0] IG_OFF_RST  = 4'h0;
  localparam logic [2:0] LO_UV_RST   = 3'h0;
  localparam logic [2:0] TIME_RST    = 3'h0;   // Ignition: 10 ms hold, 100 ms delay
  localparam logic [3:0] IG_WAKE_CODE = 4'h9;  // Rising-edge wake-up select

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic hi_ov;      // High supply above overvoltage
    logic hi_uv;      // High supply below undervoltage
    logic ig_on;      // Ignition above on threshold
    logic ig_off;     // Ignition below off threshold
    logic lo_uv;      // Low supply below threshold
    logic mr_n;       // Manual reset, active low
  } sms_cmp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_ACT  = 2'b10,
    ST_HOLD = 2'b11
  } sms_state_t;

endpackage

// *** src/sms_chan.sv ***
// Deglitch, delay and hold sequencer for one shutdown source
`timescale 1ns/1ns
module sms_chan
  import sms_pkg::*;
(
  input  wire logic          clk,          // System clock
  input  wire logic          rst_b,        // Synchronous reset, low
  input  wire logic          tick,         // Timer base enable
  input  wire logic          fault,        // Synchronised fault level
  input  wire logic [TW-1:0] delay_ticks,  // Selected delay
  input  wire logic [TW-1:0] hold_ticks,   // Selected hold
  output logic               trip,         // Fault qualified, one cycle
  output logic               warn_act,     // Warning active
  output logic               shutdown_out_n_act      // Shutdown active
);

  sms_state_t    st_r, st_nxt;
  logic [TW-1:0] glt_r, glt_nxt;
  logic [TW-1:0] cnt_r, cnt_nxt;
  logic          qual;

  // Next state: deglitch counter resets on any gap in the fault
  always_comb begin
    glt_nxt = glt_r;
    cnt_nxt = cnt_r;
    st_nxt  = st_r;
    trip    = 1'b0;
    if (!fault) begin
      glt_nxt = '0;
    end else if (tick && glt_r <= DEGLITCH_TICKS) begin
      glt_nxt = glt_r + 1'b1;
    end
    qual = fault && (glt_r > DEGLITCH_TICKS);
    unique case (st_r)
      ST_IDLE: begin
        if (qual) begin
          st_nxt  = ST_WAIT;
          cnt_nxt = '0;
          trip    = 1'b1;
        end
      end
      ST_WAIT: begin
        // Shutdown only once both delay and warning lead have passed
        if (!qual) begin
          st_nxt = ST_IDLE;
        end else if (cnt_r >= delay_ticks && cnt_r > WARN_LEAD_TICKS) begin
          st_nxt = ST_ACT;
        end else if (tick) begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_ACT: begin
        if (!fault) begin
          st_nxt  = ST_HOLD;
          cnt_nxt = '0;
        end
      end
      ST_HOLD: begin
        if (fault) begin
          st_nxt = ST_ACT;
        end else if (cnt_r >= hold_ticks) begin
          st_nxt = ST_IDLE;
        end else if (tick) begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    endcase
    warn_act = ((st_r == ST_WAIT) && cnt_r >= WARN_LEAD_TICKS)
               || st_r == ST_ACT || st_r == ST_HOLD;
    shutdown_out_n_act = (st_r == ST_ACT) || (st_r == ST_HOLD);
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r  <= ST_IDLE;
      glt_r <= '0;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      glt_r <= glt_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// *** src/sms_top.sv ***
// Supply monitor shutdown sequencer top: registers, sync, ignition, reset logic
`timescale 1ns/1ns
//
// Behaviour
// - High supply has 16-level overvoltage code at high_supply_over_threshold, undervoltage at high_supply_under_threshold.
// - High supply offers eight hold times and eight delay times.
// - Shutdown stays low for hold time after high supply returns in range.
// - High supply fault asserts shutdown only after selected delay.
// - Excursion counts only if it outlasts the deglitch time.
// - Reset follows shutdown delay and hold for high supply and ignition.
// - High supply trips latch overvoltage or undervoltage into fault register.
// - Warning goes low before shutdown, lead set against delay.
// - Ignition on threshold at ignition_on_threshold, off threshold at ignition_off_threshold, 16 levels.
// - Ignition default is level mode using on and off comparators.
// - Off code 1001 selects rising-edge wake-up, off threshold ignored.
// - Wake-up mode uses only the ignition on comparator.
// - Ignition off-driven shutdown is recorded in fault register.
// - Reset thresholds select 18.00 V over and 8.43 V under.
// - Ignition reset timing is 10 ms hold, 100 ms delay.
// - Low supply undervoltage with hold drives only the reset output.
// - Manual reset overrides every other reset source.
// - Low supply threshold in eight steps at 0x05, hold 0.1-200 ms.
module sms_top
  import sms_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF  // Cycles per timer tick
)(
  input  wire logic     clk,                 // System clock, 100 MHz
  input  wire logic     rst_b,               // Synchronous reset, low
  input  wire sms_cmp_t cmp,                 // Raw comparator results
  input  wire logic [7:0] reg_addr,          // Register address
  input  wire logic     reg_wr,              // Register write strobe
  input  wire logic [7:0] reg_wdata,         // Register write data
  output logic [7:0]    reg_rdata,           // Registered read data
  output logic [3:0]    hi_ov_code,          // Overvoltage threshold code
  output logic [3:0]    hi_uv_code,          // Undervoltage threshold code
  output logic [3:0]    ig_on_code,          // Ignition on code
  output logic [3:0]    ig_off_code,         // Ignition off code
  output logic [2:0]    lo_uv_code,          // Low supply threshold code
  output logic          shutdown_out_n,      // Shutdown, active low
  output logic          shutdown_warning_n,  // Warning, active low
  output logic          reset_out_n          // Reset, active low
);

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers
  sms_cmp_t cmp_s1_r, cmp_s2_r;

  // Two flops; only the second stage is read by logic
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmp_s1_r <= '{mr_n: 1'b1, default: 1'b0};
      cmp_s2_r <= '{mr_n: 1'b1, default: 1'b0};
    end else begin
      cmp_s1_r <= cmp;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer base divider
  localparam int unsigned DW = $clog2(TICK_CYCLES + 1);
  logic [DW-1:0] div_r, div_nxt;
  logic          tick_r, tick_nxt;

  // One-cycle enable every TICK_CYCLES clocks
  always_comb begin
    tick_nxt = 1'b0;
    div_nxt  = div_r + 1'b1;
    if (div_r == DW'(TICK_CYCLES - 1)) begin
      div_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [3:0] hi_ov_r, hi_ov_nxt;
  logic [3:0] hi_uv_r, hi_uv_nxt;
  logic [3:0] ig_on_r, ig_on_nxt;
  logic [3:0] ig_off_r, ig_off_nxt;
  logic [2:0] lo_uv_r, lo_uv_nxt;
  logic [2:0] hi_hold_r, hi_hold_nxt, hi_dly_r, hi_dly_nxt;
  logic [2:0] ig_hold_r, ig_hold_nxt, ig_dly_r, ig_dly_nxt;
  logic [2:0] rs_hold_r, rs_hold_nxt;

  // Writes land in the addressed field; unmapped writes are dropped
  always_comb begin
    hi_ov_nxt   = hi_ov_r;
    hi_uv_nxt   = hi_uv_r;
    ig_on_nxt   = ig_on_r;
    ig_off_nxt  = ig_off_r;
    lo_uv_nxt   = lo_uv_r;
    hi_hold_nxt = hi_hold_r;
    hi_dly_nxt  = hi_dly_r;
    ig_hold_nxt = ig_hold_r;
    ig_dly_nxt  = ig_dly_r;
    rs_hold_nxt = rs_hold_r;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_HI_OV:  hi_ov_nxt  = reg_wdata[3:0];
        REG_HI_UV:  hi_uv_nxt  = reg_wdata[3:0];
        REG_IG_ON:  ig_on_nxt  = reg_wdata[3:0];
        REG_IG_OFF: ig_off_nxt = reg_wdata[3:0];
        REG_LO_UV:  lo_uv_nxt  = reg_wdata[2:0];
        REG_HI_TIME: begin
          hi_hold_nxt = reg_wdata[HOLD_LSB +: 3];
          hi_dly_nxt  = reg_wdata[DELAY_LSB +: 3];
        end
        REG_IG_TIME: begin
          ig_hold_nxt = reg_wdata[HOLD_LSB +: 3];
          ig_dly_nxt  = reg_wdata[DELAY_LSB +: 3];
        end
        REG_RS_TIME: rs_hold_nxt = reg_wdata[HOLD_LSB +: 3];
        default: ;
      endcase
    end
  end

  // Defaults give 18.00 V / 8.43 V and 10 ms / 100 ms ignition timing
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hi_ov_r   <= HI_OV_RST;
      hi_uv_r   <= HI_UV_RST;
      ig_on_r   <= IG_ON_RST;
      ig_off_r  <= IG_OFF_RST;
      lo_uv_r   <= LO_UV_RST;
      hi_hold_r <= TIME_RST;
      hi_dly_r  <= TIME_RST;
      ig_hold_r <= TIME_RST;
      ig_dly_r  <= TIME_RST;
      rs_hold_r <= TIME_RST;
    end else begin
      hi_ov_r   <= hi_ov_nxt;
      hi_uv_r   <= hi_uv_nxt;
      ig_on_r   <= ig_on_nxt;
      ig_off_r  <= ig_off_nxt;
      lo_uv_r   <= lo_uv_nxt;
      hi_hold_r <= hi_hold_nxt;
      hi_dly_r  <= hi_dly_nxt;
      ig_hold_r <= ig_hold_nxt;
      ig_dly_r  <= ig_dly_nxt;
      rs_hold_r <= rs_hold_nxt;
    end
  end

  // Codes to the analog comparators come straight from the registers
  assign hi_ov_code  = hi_ov_r;
  assign hi_uv_code  = hi_uv_r;
  assign ig_on_code  = ig_on_r;
  assign ig_off_code = ig_off_r;
  assign lo_uv_code  = lo_uv_r;

  ////////////////////////////////////////////////////////////////////////////
  // Ignition interpretation
  logic ig_wake;
  logic ig_up_r, ig_up_nxt;
  logic ig_fault;

  // Level mode is a set/reset latch on the two comparators
  always_comb begin
    ig_wake   = (ig_off_r == IG_WAKE_CODE);
    ig_up_nxt = ig_up_r;
    if (cmp_s2_r.ig_on) begin
      ig_up_nxt = 1'b1;
    end else if (ig_wake || cmp_s2_r.ig_off) begin
      ig_up_nxt = 1'b0;
    end
    ig_fault = !ig_up_r;
  end

  // Starts low so an absent ignition trips the ignition channel and shuts down after its delay
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ig_up_r <= 1'b0;
    end else begin
      ig_up_r <= ig_up_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown channels
  logic hi_trip, hi_warn, hi_shutdown_out_n;
  logic ig_trip, ig_warn, ig_shutdown_out_n;

  sms_chan u_hi (
    .clk         (clk),
    .rst_b       (rst_b),
    .tick        (tick_r),
    .fault       (cmp_s2_r.hi_ov | cmp_s2_r.hi_uv),
    .delay_ticks (sms_ticks(HI_DELAY_US[hi_dly_r])),
    .hold_ticks  (sms_ticks(HI_HOLD_US[hi_hold_r])),
    .trip        (hi_trip),
    .warn_act    (hi_warn),
    .shutdown_out_n_act    (hi_shutdown_out_n)
  );

  sms_chan u_ig (
    .clk         (clk),
    .rst_b       (rst_b),
    .tick        (tick_r),
    .fault       (ig_fault),
    .delay_ticks (sms_ticks(IG_DELAY_US[ig_dly_r])),
    .hold_ticks  (sms_ticks(IG_HOLD_US[ig_hold_r])),
    .trip        (ig_trip),
    .warn_act    (ig_warn),
    .shutdown_out_n_act    (ig_shutdown_out_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Low supply and manual reset hold
  logic          rs_src;
  logic          rs_act_r, rs_act_nxt;
  logic [TW-1:0] rs_cnt_r, rs_cnt_nxt;
  logic          mr_act;

  // Any active source restarts the hold; release counts the hold out
  always_comb begin
    mr_act     = !cmp_s2_r.mr_n;
    rs_src     = cmp_s2_r.lo_uv | mr_act;
    rs_act_nxt = rs_act_r;
    rs_cnt_nxt = rs_cnt_r;
    if (rs_src) begin
      rs_act_nxt = 1'b1;
      rs_cnt_nxt = '0;
    end else if (rs_act_r) begin
      if (rs_cnt_r >= sms_ticks(RS_HOLD_US[rs_hold_r])) begin
        rs_act_nxt = 1'b0;
      end else if (tick_r) begin
        rs_cnt_nxt = rs_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rs_act_r <= 1'b1;
      rs_cnt_r <= '0;
    end else begin
      rs_act_r <= rs_act_nxt;
      rs_cnt_r <= rs_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault register, write one to clear, a new trip wins over the clear
  logic [3:0] flt_r, flt_nxt;
  logic [3:0] flt_set;
  logic       lo_uv_d_r;

  always_comb begin
    flt_set            = '0;
    flt_set[FLT_OV]    = hi_trip & cmp_s2_r.hi_ov;
    flt_set[FLT_UV]    = hi_trip & cmp_s2_r.hi_uv;
    flt_set[FLT_IGOFF] = ig_trip & !ig_wake & cmp_s2_r.ig_off;
    flt_set[FLT_LOUV]  = cmp_s2_r.lo_uv & !lo_uv_d_r;
    flt_nxt            = flt_r;
    if (reg_wr && reg_addr == REG_FAULT) begin
      flt_nxt = flt_r & ~reg_wdata[3:0];
    end
    flt_nxt = flt_nxt | flt_set;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flt_r     <= '0;
      lo_uv_d_r <= 1'b0;
    end else begin
      flt_r     <= flt_nxt;
      lo_uv_d_r <= cmp_s2_r.lo_uv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and pin outputs, all registered
  logic [7:0] rdata_nxt;
  logic       shutdown_out_n_n_nxt, warn_n_nxt, rst_n_nxt;

  // Unmapped addresses read zero; reserved bits read zero
  always_comb begin
    unique case (reg_addr)
      REG_HI_OV:   rdata_nxt = {4'h0, hi_ov_r};
      REG_HI_UV:   rdata_nxt = {4'h0, hi_uv_r};
      REG_IG_ON:   rdata_nxt = {4'h0, ig_on_r};
      REG_IG_OFF:  rdata_nxt = {4'h0, ig_off_r};
      REG_LO_UV:   rdata_nxt = {5'h00, lo_uv_r};
      REG_HI_TIME: rdata_nxt = {1'b0, hi_dly_r, 1'b0, hi_hold_r};
      REG_IG_TIME: rdata_nxt = {1'b0, ig_dly_r, 1'b0, ig_hold_r};
      REG_RS_TIME: rdata_nxt = {5'h00, rs_hold_r};
      REG_FAULT:   rdata_nxt = {4'h0, flt_r};
      default:     rdata_nxt = 8'h00;
    endcase
    shutdown_out_n_n_nxt = !(hi_shutdown_out_n | ig_shutdown_out_n);
    warn_n_nxt = !(hi_warn | ig_warn);
    // Manual reset forces reset regardless of other sources
    rst_n_nxt  = !(mr_act | rs_act_r | hi_shutdown_out_n | ig_shutdown_out_n);
  end

  // Outputs assert during reset so downstream parts stay disabled
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata          <= 8'h00;
      shutdown_out_n     <= 1'b0;
      shutdown_warning_n <= 1'b0;
      reset_out_n        <= 1'b0;
    end else begin
      reg_rdata          <= rdata_nxt;
      shutdown_out_n     <= shutdown_out_n_n_nxt;
      shutdown_warning_n <= warn_n_nxt;
      reset_out_n        <= rst_n_nxt;
    end
  end

endmodule

// *** tb/sms_rails.sv ***
// Partner model: supply rails feeding the comparator levels, and the load
`timescale 1ns/1ns
module sms_rails
  import sms_pkg::*;
(
  input  wire logic clk,             // System clock
  input  wire logic shutdown_out_n,  // Load enable, low disables
  output sms_cmp_t  cmp              // Comparator levels
);
  // Healthy rails: ignition on, manual reset idle
  localparam sms_cmp_t NORM = 6'h09;
  int unsigned         off_cnt = 0;
  logic                was_on = 1'h0;

  initial cmp = NORM;

  ////////////////////////////////////////////////////////////////////////////
  // Rails move just after an edge, like a real source seen through a bench
  task automatic drive(input sms_cmp_t v, input int n);
    @(posedge clk);
    #1 cmp = v;
    if (n > 0) begin
      repeat (n) @(posedge clk);
      #1 cmp = NORM;
    end
  endtask

  // The load counts each disable, so a stray shutdown shows up later
  always @(posedge clk) begin
    if (was_on && !shutdown_out_n) off_cnt <= off_cnt + 1;
    was_on <= shutdown_out_n;
  end
endmodule

// *** tb/sms_top_properties.sv ***
// Checker: port-level properties of the supply sequencer top
`timescale 1ns/1ns
module sms_top_properties
  import sms_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF  // Clocks per tick
)(
  input wire logic       clk,                 // Clock
  input wire logic       rst_b,               // Reset, low
  input wire sms_cmp_t   cmp,                 // Raw comparators
  input wire logic [7:0] reg_addr,            // Address
  input wire logic       reg_wr,              // Write strobe
  input wire logic [7:0] reg_wdata,           // Write data
  input wire logic [7:0] reg_rdata,           // Read data
  input wire logic [3:0] hi_ov_code,          // Over code
  input wire logic [3:0] ig_off_code,         // Ignition off code
  input wire logic       shutdown_out_n,      // Shutdown
  input wire logic       shutdown_warning_n,  // Warning
  input wire logic       reset_out_n          // Reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Any cause that may legally hold shutdown low
  logic        src;
  logic [15:0] quiet_r, quiet_nxt;
  logic        armed_r, armed_nxt;
  logic        shutdown_out_n_q_r;
  assign src = cmp.hi_ov | cmp.hi_uv | cmp.ig_off | !cmp.ig_on;

  // Quiet clocks since last cause; armed only after a real trip, not reset
  always_comb begin
    quiet_nxt = src ? 16'h0000 : quiet_r + {15'h0000, quiet_r != 16'hFFFF};
    armed_nxt = armed_r | (shutdown_out_n_q_r & !shutdown_out_n);
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      quiet_r  <= 16'h0000;
      armed_r  <= 1'h0;
      shutdown_out_n_q_r <= 1'h0;
    end else begin
      quiet_r  <= quiet_nxt;
      armed_r  <= armed_nxt;
      shutdown_out_n_q_r <= shutdown_out_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence wr_to(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence held_low(logic s);
    !s [*5];
  endsequence

  ov_code_a: assert property (
    wr_to(REG_HI_OV) |=> hi_ov_code == $past(reg_wdata[3:0]))
    else $error("over code not taken");
  off_code_a: assert property (
    wr_to(REG_IG_OFF) |=> ig_off_code == $past(reg_wdata[3:0]))
    else $error("ignition off code not taken");
  ov_read_a: assert property (
    $past(reg_addr) == REG_HI_OV |-> reg_rdata == {4'h0, $past(hi_ov_code)})
    else $error("over code read back wrong");
  warn_first_a: assert property (
    $fell(shutdown_out_n) |-> !$past(shutdown_warning_n))
    else $error("shutdown without earlier warning");
  reset_follow_a: assert property (
    !shutdown_out_n |-> !reset_out_n)
    else $error("reset high during shutdown");
  manual_reset_a: assert property (
    held_low(cmp.mr_n) |-> !reset_out_n)
    else $error("manual reset ignored");
  low_reset_a: assert property (
    held_low(!cmp.lo_uv) |-> !reset_out_n)
    else $error("low supply reset missing");
  shutdown_out_n_cause_a: assert property (
    $fell(shutdown_out_n) |-> $past(src, 12))
    else $error("shutdown without lasting cause");
  hold_min_a: assert property (
    armed_r && $rose(shutdown_out_n) |-> quiet_r >= 6 * TICK_CYCLES)
    else $error("shutdown released before hold");
endmodule

// *** tb/sms_top_bench.sv ***
// Bench: self-checking run of the supply sequencer against a behavioural model
`timescale 1ns/1ns
module sms_top_bench
  import sms_pkg::*;
;
  localparam int unsigned TK = 1;  // One clock a tick keeps long timers short
  localparam sms_cmp_t    NORM = 6'h09;
  localparam logic [7:0]  ADDRS [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                                         8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
  logic       clk = 1'h0;
  logic       rst_b = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [3:0] hi_ov_code, hi_uv_code, ig_on_code, ig_off_code;
  logic [2:0] lo_uv_code;
  logic       shutdown_out_n, shutdown_warning_n, reset_out_n;
  sms_cmp_t   cmp;
  logic [7:0] mdl [256] = '{default: 8'h00};  // Register model
  logic [3:0] flt = 4'h0;                     // Fault register model
  logic [15:0] lfsr_r = 16'hC2B2;
  int         num_errors = 0;
  int         n_checks = 0;

  always #5 clk = ~clk;

  sms_rails rails (.clk(clk), .shutdown_out_n(shutdown_out_n), .cmp(cmp));
  sms_top #(.TICK_CYCLES(TK)) uut (
    .clk(clk), .rst_b(rst_b), .cmp(cmp), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hi_ov_code(hi_ov_code),
    .hi_uv_code(hi_uv_code), .ig_on_code(ig_on_code), .ig_off_code(ig_off_code),
    .lo_uv_code(lo_uv_code), .shutdown_out_n(shutdown_out_n),
    .shutdown_warning_n(shutdown_warning_n), .reset_out_n(reset_out_n));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Unused upper bits read back as zero
  function automatic logic [7:0] mask(input logic [7:0] a);
    case (a)
      REG_HI_OV, REG_HI_UV, REG_IG_ON, REG_IG_OFF: return 8'h0F;
      REG_LO_UV, REG_RS_TIME: return 8'h07;
      REG_HI_TIME, REG_IG_TIME: return 8'h77;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic pick(input int w);
    return w == 0 ? shutdown_out_n : w == 1 ? shutdown_warning_n : reset_out_n;
  endfunction

  task automatic ok(input logic c, input string what);
    n_checks++;
    if (c !== 1'h1) begin
      $display("unexpected at %0t: %s", $time, what);
      num_errors++;
    end
  endtask
  // Fault register is write-one-to-clear, the rest store masked data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(posedge clk);
    #1 reg_wr = 1'h0;
    if (a == REG_FAULT) flt = flt & ~d[3:0];
    else mdl[a] = d & mask(a);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1 reg_addr = a;
    @(posedge clk);
    #1 ok(reg_rdata === ((a == REG_FAULT) ? {4'h0, flt} : mdl[a]), "read");
  endtask
  // Bounded wait for an output level; running out ends the run
  task automatic wait_for(input int w, input logic v, output int n);
    n = 0;
    while (pick(w) !== v && n < 30000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 30000) begin
      ok(1'h0, "wait ran out");
      give_verdict();
    end
  endtask

  // One qualified fault: warning, shutdown with reset, flag, then hold
  task automatic run_fault(input sms_cmp_t bad, input logic [3:0] flag_v,
                           input logic ign, input int code);
    int dly;
    int hold;
    int tw;
    int ts;
    dly  = (ign ? IG_DELAY_US[code] : HI_DELAY_US[code]) / TICK_US * TK;
    hold = (ign ? IG_HOLD_US[code] : HI_HOLD_US[code]) / TICK_US * TK;
    rails.drive(bad, 0);
    wait_for(1, 1'h0, tw);
    wait_for(0, 1'h0, ts);
    ok(ts > 0 && reset_out_n === 1'h0, "warning lead or reset");
    ts = ts + tw;
    ok(ts >= dly + 6 && ts <= dly + 14, "delay window");
    ts = tw - (DEGLITCH_TICKS + WARN_LEAD_TICKS) * TK;  // Warning time past deglitch and lead, in clocks
    ok(ts >= 0 && ts <= 8, "warning lead");
    flt = flt | flag_v;
    rd(REG_FAULT);
    rails.drive(NORM, 0);
    wait_for(0, 1'h1, ts);
    ok(ts >= hold && ts <= hold + 8 && reset_out_n === 1'h1, "hold window");
    wr(REG_FAULT, 8'h0F);
    rd(REG_FAULT);
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int k;
    repeat (12) @(posedge clk);
    #1 rst_b = 1'h1;
    foreach (ADDRS[i]) rd(ADDRS[i]);
    $display("test reset_values done");
    // Random codes, one unmapped place among them
    for (int i = 0; i < 12; i++) begin
      lfsr_r = lfsr(lfsr_r);
      wr(ADDRS[(i % 6 == 5) ? 9 : i % 6], lfsr_r[7:0]);
      rd(ADDRS[(i % 6 == 5) ? 9 : i % 6]);
      ok({hi_ov_code, hi_uv_code, ig_on_code, ig_off_code, lo_uv_code} ===
         {mdl[1][3:0], mdl[2][3:0], mdl[3][3:0], mdl[4][3:0], mdl[5][2:0]}, "codes");
    end
    wr(REG_RS_TIME, 8'h07);
    wr(REG_HI_OV, 8'h00);
    wr(REG_HI_UV, 8'h00);
    wr(REG_IG_ON, 8'h00);
    wr(REG_IG_OFF, 8'h00);
    wr(REG_HI_TIME, 8'h66);
    wr(REG_IG_TIME, 8'h77);
    wait_for(2, 1'h1, n);
    wait_for(0, 1'h1, n);
    $display("test registers done");
    run_fault(6'h21, 4'h1, 1'h0, 6);
    wr(REG_HI_TIME, 8'h77);
    run_fault(6'h11, 4'h2, 1'h0, 7);
    run_fault(6'h05, 4'h4, 1'h1, 7);
    $display("test faults done");
    // A dip shorter than the deglitch time leaves no trace
    k = rails.off_cnt;
    rails.drive(6'h11, 4);
    repeat (40) @(posedge clk);
    ok(rails.off_cnt == k, "glitch ignored");
    rd(REG_FAULT);
    // Wake mode: off comparator ignored, falling on comparator trips
    wr(REG_IG_OFF, {4'h0, IG_WAKE_CODE});
    rails.drive(6'h0D, 0);
    repeat (40) @(posedge clk);
    ok(rails.off_cnt == k, "off seen in wake mode");
    rails.drive(6'h01, 0);
    wait_for(0, 1'h0, n);
    ok(n <= 30, "wake trip late");
    rd(REG_FAULT);
    rails.drive(NORM, 0);
    wait_for(0, 1'h1, n);
    wr(REG_FAULT, 8'h0F);
    wr(REG_IG_OFF, 8'h00);
    $display("test glitch_wake done");
    // Reset-only sources: low supply, then manual reset
    for (int i = 0; i < 2; i++) begin
      rails.drive(i ? 6'h08 : 6'h0B, 20);
      ok(reset_out_n === 1'h0 && shutdown_out_n === 1'h1, "reset only");
      flt = flt | (i ? 4'h0 : 4'h8);
      rd(REG_FAULT);
      wait_for(2, 1'h1, n);
      ok(n >= RS_HOLD_US[7] / TICK_US - 2 && n <= 20, "reset hold");
      wr(REG_FAULT, 8'h0F);
    end
    ok(rails.off_cnt == k + 1, "load disable count");
    $display("test reset_sources done");
    give_verdict();
  end
endmodule

bind sms_top sms_top_properties #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk(clk), .rst_b(rst_b), .cmp(cmp), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hi_ov_code(hi_ov_code),
  .ig_off_code(ig_off_code), .shutdown_out_n(shutdown_out_n),
  .shutdown_warning_n(shutdown_warning_n), .reset_out_n(reset_out_n));
